// ==== include/nvmac_pkg.sv ====
// Constants shared by the data byte store access control block.
// Assumes a 100 MHz core clock and an APB register port with byte offsets.
package nvmac_pkg;
  // Core clock rate in MHz
  localparam int CLK_MHZ = 100;
  // Power-up timer period in microseconds, and in cycles
  localparam int PWRT_TIME_US = 64;
  localparam int PWRT_CYCLES = PWRT_TIME_US * CLK_MHZ;
  // Self-timed byte write time in microseconds, and in cycles
  localparam int WRITE_TIME_US = 4;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  // Array geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register byte offsets on the APB port
  localparam logic [7:0] OFS_BYTE_ADDRESS = 8'h00;
  localparam logic [7:0] OFS_BYTE_DATA = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_UNLOCK_PORT = 8'h0C;
  localparam logic [7:0] OFS_FLAG_TWO = 8'h10;
  localparam logic [7:0] OFS_ENABLE_TWO = 8'h14;
  localparam logic [7:0] OFS_PRIORITY_TWO = 8'h18;
  localparam logic [7:0] OFS_CORE_CONTROL = 8'h1C;

  // Control register fields
  localparam int CTL_FLASH_SEL = 7;
  localparam int CTL_CFG_PICK = 6;
  localparam int CTL_ABORT = 3;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_LAUNCH = 1;
  localparam int CTL_FETCH = 0;
  // Done flag, enable and priority sit at the same position
  localparam int DONE_BIT = 4;
  // Global gate in the core interrupt control register
  localparam int GATE_BIT = 7;

  // Reset value of the byte address and byte data registers
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Unlock values
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

  // Unlock sequencer states
  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_GOT_FIRST,
    UNL_ARMED
  } nvmac_unlock_type;
endpackage : nvmac_pkg

// ==== rtl/nvmac_unlock.sv ====
// Unlock sequence recogniser for the byte store write launch.
// Assumes one-cycle write strobes from the register port, at most one a cycle.
`timescale 1ns/1ps
module nvmac_unlock (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic unlock_wr,
  input wire logic other_wr,
  input wire logic [7:0] wdata,
  output logic armed
);
  nvmac_pkg::nvmac_unlock_type state;

  // The port stores nothing; it only moves this sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= nvmac_pkg::UNL_IDLE;
    end else if (other_wr) begin
      state <= nvmac_pkg::UNL_IDLE;
    end else if (unlock_wr) begin
      if (wdata == nvmac_pkg::UNLOCK_FIRST) begin
        state <= nvmac_pkg::UNL_GOT_FIRST;
      end else if (state == nvmac_pkg::UNL_GOT_FIRST && wdata == nvmac_pkg::UNLOCK_SECOND) begin
        state <= nvmac_pkg::UNL_ARMED;
      end else begin
        state <= nvmac_pkg::UNL_IDLE;
      end
    end
  end

  assign armed = (state == nvmac_pkg::UNL_ARMED);
endmodule : nvmac_unlock

// ==== rtl/nvmac_array.sv ====
// Byte array with two read ports and one self-timed write engine.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/1ps
module nvmac_array #(
  parameter int DEPTH = 256,
  parameter int WRITE_CYCLES = nvmac_pkg::WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [nvmac_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [nvmac_pkg::DATA_W-1:0] wr_data,
  input wire logic [nvmac_pkg::ADDR_W-1:0] rd_addr_a,
  output logic [nvmac_pkg::DATA_W-1:0] rd_data_a,
  input wire logic [nvmac_pkg::ADDR_W-1:0] rd_addr_b,
  output logic [nvmac_pkg::DATA_W-1:0] rd_data_b,
  output logic busy,
  output logic done
);
  logic [nvmac_pkg::DATA_W-1:0] mem [DEPTH];
  logic [15:0] count;
  logic [nvmac_pkg::ADDR_W-1:0] hold_addr;
  logic [nvmac_pkg::DATA_W-1:0] hold_data;

  // One byte per address, no wider words
  assign rd_data_a = mem[rd_addr_a];
  assign rd_data_b = mem[rd_addr_b];

  // Write timer; the cell is committed only at the end so a reset aborts it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= 16'h0000;
      hold_addr <= '0;
      hold_data <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        count <= 16'(WRITE_CYCLES - 1);
        hold_addr <= wr_addr;
        hold_data <= wr_data;
      end else if (busy) begin
        if (count == 16'h0000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 16'h0001;
        end
      end
    end
  end

  // Array cells carry no reset, like real storage
  always_ff @(posedge clock) begin
    if (busy && count == 16'h0000) begin
      mem[hold_addr] <= hold_data;
    end
  end
endmodule : nvmac_array

// ==== rtl/nvmac_top.sv ====
// Data byte store access control: APB registers, unlock, write timing.
// Assumes APB4 master on clock; por_n low only at power-on, rst_n on any reset.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module nvmac_top #(
  parameter int PWRT_CYCLES = nvmac_pkg::PWRT_CYCLES,
  parameter int WRITE_CYCLES = nvmac_pkg::WRITE_CYCLES,
  parameter int DEPTH = 256
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cp_enable,
  input wire logic ext_req,
  input wire logic ext_write,
  input wire logic [7:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  output logic [7:0] ext_rdata,
  output logic ext_ack,
  output logic ext_refused,
  output logic nvm_irq
);
  // Decode of one register offset, used by every strobe and the read mux
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, nvmac_pkg::OFS_BYTE_ADDRESS) | hit(a, nvmac_pkg::OFS_BYTE_DATA)
           | hit(a, nvmac_pkg::OFS_CONTROL) | hit(a, nvmac_pkg::OFS_UNLOCK_PORT)
           | hit(a, nvmac_pkg::OFS_FLAG_TWO) | hit(a, nvmac_pkg::OFS_ENABLE_TWO)
           | hit(a, nvmac_pkg::OFS_PRIORITY_TWO) | hit(a, nvmac_pkg::OFS_CORE_CONTROL);
  endfunction : mapped

  logic [7:0] nvm_byte_address;
  logic [7:0] nvm_byte_data;
  logic flash_space_select;
  logic configuration_space_pick;
  logic program_permit;
  logic program_abort_flag;
  logic nvm_done_flag;
  logic nvm_done_irq_enable;
  logic nvm_done_priority;
  logic global_irq_gate;
  logic core_write;
  logic inflight;
  logic reset_seen;
  logic pwrt_done;
  logic [15:0] pwrt_count;
  logic armed;
  logic busy;
  logic done;
  logic [7:0] rd_core;
  logic [7:0] rd_ext;
  logic [7:0] wdata;
  logic [7:0] ctl_read;
  logic access;
  logic wr_acc;
  logic wr_ctl;
  logic wr_unlock;
  logic wr_other;
  logic launch_go;
  logic fetch_go;
  logic ext_ok;
  logic ext_go;
  logic abort_set;

  // The access phase is the cycle where pready is high under psel and penable
  assign access = psel & penable & pready;
  assign wr_acc = access & pwrite & pstrb[0];
  assign wdata = pwdata[7:0];
  assign wr_ctl = wr_acc & hit(paddr, nvmac_pkg::OFS_CONTROL);
  assign wr_unlock = wr_acc & hit(paddr, nvmac_pkg::OFS_UNLOCK_PORT);
  assign wr_other = wr_acc & ~wr_unlock & mapped(paddr);

  // Launch needs unlock, permit set by an earlier write, timer expired, data space
  assign launch_go = wr_ctl & wdata[nvmac_pkg::CTL_LAUNCH] & program_permit
                   & armed & pwrt_done & ~busy
                   & ~flash_space_select & ~configuration_space_pick;
  // Fetch is refused in flash or configuration space
  assign fetch_go = wr_ctl & wdata[nvmac_pkg::CTL_FETCH] & ~busy
                  & ~wdata[nvmac_pkg::CTL_FLASH_SEL] & ~wdata[nvmac_pkg::CTL_CFG_PICK];

  // External port: code protect shuts it out, the core never sees that bit
  assign ext_ok = ~cp_enable & ~(ext_write & (busy | launch_go | ~pwrt_done));
  assign ext_go = ext_req & ext_write & ext_ok;

  // A reset that lands inside a write leaves inflight set when rst_n lifts
  assign abort_set = ~reset_seen & inflight;

  nvmac_unlock u_unlock (
    .clock(clock),
    .rst_n(rst_n),
    .unlock_wr(wr_unlock),
    .other_wr(wr_other),
    .wdata(wdata),
    .armed(armed)
  );

  nvmac_array #(
    .DEPTH(DEPTH),
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_array (
    .clock(clock),
    .rst_n(rst_n),
    .start(launch_go | ext_go),
    .wr_addr(launch_go ? nvm_byte_address : ext_addr),
    .wr_data(launch_go ? nvm_byte_data : ext_wdata),
    .rd_addr_a(nvm_byte_address),
    .rd_data_a(rd_core),
    .rd_addr_b(ext_addr),
    .rd_data_b(rd_ext),
    .busy(busy),
    .done(done)
  );

  // Power-up timer runs once after power-on only
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      pwrt_count <= 16'h0000;
      pwrt_done <= 1'b0;
    end else if (!pwrt_done) begin
      if (pwrt_count == 16'(PWRT_CYCLES - 1)) begin
        pwrt_done <= 1'b1;
      end else begin
        pwrt_count <= pwrt_count + 16'h0001;
      end
    end
  end

  // Goes high on the first edge after any reset; marks the abort check window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reset_seen <= 1'b0;
    end else begin
      reset_seen <= 1'b1;
    end
  end

  // Write in progress survives a plain reset so the abort can be detected
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      inflight <= 1'b0;
    end else if (abort_set || done) begin
      inflight <= 1'b0;
    end else if (launch_go || ext_go) begin
      inflight <= 1'b1;
    end
  end

  // Abort flag and selects live on power-on reset so an abort stays traceable
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      program_abort_flag <= 1'b0;
      flash_space_select <= 1'b0;
      configuration_space_pick <= 1'b0;
    end else begin
      if (abort_set) begin
        program_abort_flag <= 1'b1;
      end else if (wr_ctl && !busy && !wdata[nvmac_pkg::CTL_ABORT]) begin
        program_abort_flag <= 1'b0;
      end
      if (wr_ctl && !busy && reset_seen) begin
        flash_space_select <= wdata[nvmac_pkg::CTL_FLASH_SEL];
        configuration_space_pick <= wdata[nvmac_pkg::CTL_CFG_PICK];
      end
    end
  end

  // Permit is cleared by reset and never by hardware
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      program_permit <= 1'b0;
    end else if (wr_ctl && !busy) begin
      program_permit <= wdata[nvmac_pkg::CTL_PERMIT];
    end
  end

  // Launch bit tracks a core-started write and clears itself at the end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_write <= 1'b0;
    end else if (launch_go) begin
      core_write <= 1'b1;
    end else if (done) begin
      core_write <= 1'b0;
    end
  end

  // Address and data are frozen while a write runs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nvm_byte_address <= nvmac_pkg::RST_BYTE;
      nvm_byte_data <= nvmac_pkg::RST_BYTE;
    end else if (!busy) begin
      if (wr_acc && hit(paddr, nvmac_pkg::OFS_BYTE_ADDRESS)) begin
        nvm_byte_address <= wdata;
      end
      if (fetch_go) begin
        nvm_byte_data <= rd_core;
      end else if (wr_acc && hit(paddr, nvmac_pkg::OFS_BYTE_DATA)) begin
        nvm_byte_data <= wdata;
      end
    end
  end

  // Done flag: a core-started write completing in the same cycle as a clear wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nvm_done_flag <= 1'b0;
    end else if (done && core_write) begin
      nvm_done_flag <= 1'b1;
    end else if (wr_acc && hit(paddr, nvmac_pkg::OFS_FLAG_TWO)) begin
      nvm_done_flag <= wdata[nvmac_pkg::DONE_BIT];
    end
  end

  // Interrupt enable, priority and global gate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nvm_done_irq_enable <= 1'b0;
      nvm_done_priority <= 1'b0;
      global_irq_gate <= 1'b0;
    end else begin
      if (wr_acc && hit(paddr, nvmac_pkg::OFS_ENABLE_TWO)) begin
        nvm_done_irq_enable <= wdata[nvmac_pkg::DONE_BIT];
      end
      if (wr_acc && hit(paddr, nvmac_pkg::OFS_PRIORITY_TWO)) begin
        nvm_done_priority <= wdata[nvmac_pkg::DONE_BIT];
      end
      if (wr_acc && hit(paddr, nvmac_pkg::OFS_CORE_CONTROL)) begin
        global_irq_gate <= wdata[nvmac_pkg::GATE_BIT];
      end
    end
  end

  // Request is registered, so it follows the flag by one cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nvm_irq <= 1'b0;
    end else begin
      nvm_irq <= nvm_done_flag & nvm_done_irq_enable & global_irq_gate;
    end
  end

  // Control read image; bits 5 and 4 and fetch read zero
  always_comb begin
    ctl_read = 8'h00;
    ctl_read[nvmac_pkg::CTL_FLASH_SEL] = flash_space_select;
    ctl_read[nvmac_pkg::CTL_CFG_PICK] = configuration_space_pick;
    ctl_read[nvmac_pkg::CTL_ABORT] = program_abort_flag;
    ctl_read[nvmac_pkg::CTL_PERMIT] = program_permit;
    ctl_read[nvmac_pkg::CTL_LAUNCH] = core_write;
  end

  // APB answer: no wait state; read data and pready come from flops loaded in the setup cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (1'b1)
          hit(paddr, nvmac_pkg::OFS_BYTE_ADDRESS): prdata[7:0] <= nvm_byte_address;
          hit(paddr, nvmac_pkg::OFS_BYTE_DATA): prdata[7:0] <= nvm_byte_data;
          hit(paddr, nvmac_pkg::OFS_CONTROL): prdata[7:0] <= ctl_read;
          hit(paddr, nvmac_pkg::OFS_FLAG_TWO): prdata[nvmac_pkg::DONE_BIT] <= nvm_done_flag;
          hit(paddr, nvmac_pkg::OFS_ENABLE_TWO): prdata[nvmac_pkg::DONE_BIT] <= nvm_done_irq_enable;
          hit(paddr, nvmac_pkg::OFS_PRIORITY_TWO): prdata[nvmac_pkg::DONE_BIT] <= nvm_done_priority;
          hit(paddr, nvmac_pkg::OFS_CORE_CONTROL): prdata[nvmac_pkg::GATE_BIT] <= global_irq_gate;
          default: prdata <= 32'h0000_0000; // Unlock port reads zero
        endcase
      end
    end
  end

  // External programming answers one cycle after the request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_ack <= 1'b0;
      ext_refused <= 1'b0;
      ext_rdata <= 8'h00;
    end else begin
      ext_ack <= ext_req & ext_ok;
      ext_refused <= ext_req & ~ext_ok;
      if (ext_req && ext_ok && !ext_write) begin
        ext_rdata <= rd_ext;
      end
    end
  end
endmodule : nvmac_top

// ==== verification/nvmac_asserts.sv ====
// Port checker for the byte store access control block.
// Assumes it is bound into nvmac_top; one clock domain.
`timescale 1ns/1ps
module nvmac_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cp_enable,
  input wire logic ext_req,
  input wire logic ext_ack,
  input wire logic ext_refused
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Bus answers, upper lanes and places that read zero
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("ready late");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
  a_upper_lanes_zero: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper bits set");
  a_ctrl_gap_zero: assert property (psel && !penable && !pwrite && paddr == 8'h08 |=> prdata[5:4] == 2'b00)
    else $error("control gap bits set");
  a_unlock_no_store: assert property (psel && !penable && !pwrite && paddr == 8'h0C |=> prdata == 32'h00000000)
    else $error("unlock port read nonzero");
  a_slverr_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  // External port: protect refuses, one answer per request
  a_protect_refuses: assert property (ext_req && cp_enable |=> ext_refused && !ext_ack)
    else $error("protected access served");
  a_ext_one_answer: assert property (ext_req |=> ext_ack != ext_refused) else $error("bad ext answer");
  a_ext_quiet: assert property (!ext_req |=> !ext_ack && !ext_refused) else $error("answer unasked");
endmodule : nvmac_asserts

bind nvmac_top nvmac_asserts u_chk (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .cp_enable, .ext_req, .ext_ack, .ext_refused);

// ==== verification/nvmac_ext_prog.sv ====
// External programmer model on the access port of the block.
// Assumes the block answers on the edge after a request.
`timescale 1ns/1ps
module nvmac_ext_prog (
  input wire logic clock,
  output logic ext_req,
  output logic ext_write,
  output logic [7:0] ext_addr,
  output logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata,
  input wire logic ext_ack,
  input wire logic ext_refused
);
  initial begin
    ext_req = 1'b0;
    ext_write = 1'b0;
    ext_addr = 8'h00;
    ext_wdata = 8'h00;
  end
  // One request; r = {ack, refused, read data}
  task automatic op(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [9:0] r);
    @(posedge clock);
    ext_req <= 1'b1;
    ext_write <= wr;
    ext_addr <= a;
    ext_wdata <= d;
    @(posedge clock);
    ext_req <= 1'b0;
    // Released lines flip so stale values cannot pass
    ext_addr <= ~a;
    ext_wdata <= ~d;
    @(posedge clock);
    r = {ext_ack, ext_refused, ext_rdata};
  endtask : op
endmodule : nvmac_ext_prog

// ==== verification/nvmac_tb_top.sv ====
// Self-checking bench for the byte store access control block.
// Assumes short timer parameters; an APB master task drives the registers.
`timescale 1ns/1ps
module nvmac_tb_top;
  localparam int PWRT = 40;
  // Write time long enough that two register writes land inside it
  localparam int WCYC = 12;
  logic clock, rst_n, por_n, psel, penable, pwrite, cp_enable, ext_req, ext_write;
  logic pready, pslverr, ext_ack, ext_refused, nvm_irq;
  logic [7:0] paddr, ext_addr, ext_wdata, ext_rdata, a, d;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [64:0] expq[$];
  logic [64:0] e;
  logic [9:0] r;
  int err_count, num_checks;

  nvmac_top #(.PWRT_CYCLES(PWRT), .WRITE_CYCLES(WCYC)) u_dut (.clock, .rst_n, .por_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cp_enable, .ext_req, .ext_write,
    .ext_addr, .ext_wdata, .ext_rdata, .ext_ack, .ext_refused, .nvm_irq);
  nvmac_ext_prog u_prog (.clock, .ext_req, .ext_write, .ext_addr, .ext_wdata, .ext_rdata, .ext_ack,
    .ext_refused);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; an idle cycle after keeps psel single-driven per step
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : xfer

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    xfer(1'b1, ad, wd);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] m = 32'hFFFFFFFF,
    input logic s = 1'b0);
    expq.push_back({s, m, ex & m});
    xfer(1'b0, ad, 32'h00000000);
  endtask : rd

  task automatic unlock();
    wr(8'h0C, 32'h00000055);
    wr(8'h0C, 32'h000000AA);
    wr(8'h08, 32'h00000006);
  endtask : unlock

  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // Read monitor takes the oldest note at each completed read
  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite) begin
      e = expq.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[64]});
      chk(prdata & e[63:32], e[31:0]);
    end
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Watchdog well past the few hundred cycles the tests need
  initial begin
    #20us;
    err_count++;
    results();
  end

  initial begin
    {rst_n, por_n, psel, penable, pwrite, cp_enable} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    err_count = 0;
    num_checks = 0;
    a = 8'($urandom(32'h4CDAD3FD));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clock);
    rd(8'h08, 32'h00000000);
    rd(8'h0C, 32'h00000000);
    rd(8'h20, 32'h00000000, 32'hFFFFFFFF, 1'b1);
    wr(8'h08, 32'h00000004);
    unlock();
    rd(8'h08, 32'h00000004);
    // External writes are refused while the power-up timer runs
    u_prog.op(1'b1, 8'h00, 8'h00, r);
    chk({30'h0, r[9:8]}, 32'h00000001);
    $display("power-up test done");
    repeat (PWRT) @(posedge clock);
    for (int i = 0; i < 2; i++) begin
      a = 8'($urandom);
      d = 8'($urandom);
      wr(8'h00, {24'h0, a});
      wr(8'h04, {24'h0, d});
      unlock();
      rd(8'h08, 32'h00000006);
      // Both writes land while the write engine is still busy
      wr(8'h00, {24'h0, ~a});
      wr(8'h04, {24'h0, ~d});
      repeat (WCYC) @(posedge clock);
      rd(8'h08, 32'h00000004);
      rd(8'h04, {24'h0, d});
      rd(8'h10, 32'h00000010);
      wr(8'h10, 32'h00000000);
      wr(8'h08, 32'h00000005);
      rd(8'h04, {24'h0, d});
    end
    $display("write test done");
    wr(8'h0C, 32'h00000055);
    wr(8'h00, {24'h0, a});
    wr(8'h0C, 32'h000000AA);
    wr(8'h08, 32'h00000006);
    rd(8'h08, 32'h00000004);
    wr(8'h08, 32'h00000000);
    unlock();
    rd(8'h08, 32'h00000004);
    $display("unlock test done");
    wr(8'h18, 32'h000000FF);
    rd(8'h18, 32'h00000010);
    wr(8'h14, 32'h00000010);
    wr(8'h1C, 32'h00000080);
    unlock();
    repeat (WCYC + 3) @(posedge clock);
    chk({31'h0, nvm_irq}, 32'h00000001);
    wr(8'h10, 32'h00000000);
    repeat (2) @(posedge clock);
    chk({31'h0, nvm_irq}, 32'h00000000);
    $display("irq test done");
    u_prog.op(1'b0, a, 8'h00, r);
    chk({22'h0, r}, {22'h0, 2'b10, d});
    cp_enable <= 1'b1;
    u_prog.op(1'b1, a, ~d, r);
    chk({30'h0, r[9:8]}, 32'h00000001);
    wr(8'h08, 32'h00000005);
    rd(8'h04, {24'h0, d});
    cp_enable <= 1'b0;
    $display("protect test done");
    // A fetch with the selects set must leave the data register alone
    wr(8'h04, {24'h0, ~d});
    wr(8'h08, 32'h000000C5);
    rd(8'h08, 32'h000000C4);
    rd(8'h04, {24'h0, ~d});
    wr(8'h08, 32'h00000004);
    $display("select test done");
    unlock();
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(8'h08, 32'h00000008);
    // The cut write must not have reached the cell
    wr(8'h00, {24'h0, a});
    wr(8'h08, 32'h00000001);
    rd(8'h04, {24'h0, d});
    $display("abort test done");
    results();
  end
endmodule : nvmac_tb_top
